/* hdl/lrr_defs.svh */
// Purpose: Constants of the local/remote run arbiter
// Assumes: Included by bare name
// Notes:   Terminal function codes other than Fx, Rx, run permit are plain defaults
`ifndef LRR_DEFS_SVH
`define LRR_DEFS_SVH
`define LRR_NUM_MFI       7
`define LRR_ESC_LOCREM    2'h2
`define LRR_SRC_KEYPAD    3'h0
`define LRR_SRC_TWO_WIRE  3'h1
`define LRR_SRC_RUN_DIR   3'h2
`define LRR_SRC_SERIAL    3'h3
`define LRR_SRC_FIELDBUS  3'h4
`define LRR_SRC_USER_SEQ  3'h5
`define LRR_FN_FX         6'h01
`define LRR_FN_RX         6'h02
`define LRR_FN_RUN_PERMIT 6'h0d
`define LRR_FN_JOG_FWD    6'h2e
`define LRR_FN_JOG_REV    6'h2f
`define LRR_FN_PRE_EXCITE 6'h30
`define LRR_LOCK_NONE     2'h0
`define LRR_LOCK_FWD      2'h1
`define LRR_LOCK_REV      2'h2
`define LRR_SS_PWRON_BIT  4
`define LRR_BOOT_SETTLE   2'h2
`define LRR_CLK_KHZ       25000
`define LRR_FLASH_MS      250
`endif

/* hdl/lrr_pkg.sv */
// Purpose: Types of the local/remote run arbiter
// Assumes: lrr_defs.svh gives the widths
// Notes:   Configuration is static or changes from the core clock domain
`include "lrr_defs.svh"
package lrr_pkg;
	// One-hot control mode
	typedef enum logic [1:0] {
		LRR_REMOTE = 2'b01,
		LRR_LOCAL  = 2'b10
	} lrr_mode_e;

	// Settings bundle
	typedef struct packed {
		logic [1:0]                       escape_key_function;
		logic [2:0]                       cmd_source;
		logic [1:0]                       dir_lock;
		logic                             run_on_powerup;
		logic [7:0]                       speed_search_options;
		logic [`LRR_NUM_MFI-1:0][5:0]     mfi_function;
	} lrr_cfg_s;

	// Decision bundle to the output stage
	typedef struct packed {
		logic run;
		logic reverse;
		logic jog;
		logic jog_reverse;
		logic pre_excite;
		logic speed_search;
		logic accel_from_zero;
	} lrr_drv_s;
endpackage

/* hdl/lrr_arbiter.sv */
// Purpose: Local/remote run-command arbitration for a motor drive
// Assumes: Keys and terminals are raw pins; settings and remote commands are core_clk logic
// Notes:   Stopping means the ramp decelerates to 0 Hz; the output stage stays powered
`timescale 1ns/1ps
`include "lrr_defs.svh"
module lrr_arbiter
	import lrr_pkg::*;
#(
	parameter int unsigned FLASH_CYC = `LRR_FLASH_MS * `LRR_CLK_KHZ
) (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire lrr_cfg_s                cfg,
	input  wire logic                    fault_reset_strap,
	input  wire logic                    key_esc,
	input  wire logic                    key_run,
	input  wire logic                    key_stop,
	input  wire logic                    key_rev,
	input  wire logic [`LRR_NUM_MFI-1:0] multifunction_inputs,
	input  wire logic                    rmt_cmd_valid,
	input  wire logic                    rmt_run,
	input  wire logic                    rmt_rev,
	output lrr_drv_s                     drv,
	output logic                         local_mode,
	output logic                         local_lamp
);
	localparam int W = `LRR_NUM_MFI + 5;

	// True when any input carrying the given function code is on
	function automatic logic fn_on(input logic [`LRR_NUM_MFI-1:0] lv,
	                               input logic [`LRR_NUM_MFI-1:0][5:0] codes,
	                               input logic [5:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < `LRR_NUM_MFI; i++) begin
			hit = hit | (lv[i] & (codes[i] == code));
		end
		return hit;
	endfunction

	logic [W-1:0]            pin_raw;
	logic [W-1:0]            s2;
	logic [W-1:0]            s3;
	logic [W-1:0]            rise;
	logic [`LRR_NUM_MFI-1:0] mfi;
	logic                    esc_p;
	logic                    run_p;
	logic                    stop_p;
	logic                    rev_p;
	logic                    strap;
	lrr_mode_e               mode;
	logic [1:0]              boot_cnt;
	logic                    boot_cap;
	logic                    boot_done;
	logic                    en;
	logic                    en_q;
	logic                    go_local;
	logic                    go_remote;
	logic                    post_fault;
	logic                    term_armed;
	logic                    need_all_off;
	logic                    pwr_start;
	logic                    run_q;
	logic                    rev_q;
	logic                    fx;
	logic                    rx;
	logic                    permit;
	logic                    jogf;
	logic                    jogr;
	logic                    pre;
	logic                    src_term;
	logic                    src_digital;
	logic                    keypad_ctl;
	logic                    t_run;
	logic                    t_rev;
	logic                    want_run;
	logic                    want_rev;
	logic                    blocked;
	logic                    next_run;
	logic [31:0]             flash_cnt;

	// Two-flop synchronisers plus an edge stage, one per pin
	assign pin_raw = {fault_reset_strap, key_esc, key_run, key_stop, key_rev,
	                  multifunction_inputs};
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_sync
			logic q1;
			logic q2;
			logic q3;
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					q1 <= 1'b0;
					q2 <= 1'b0;
					q3 <= 1'b0;
				end else begin
					q1 <= pin_raw[g];
					q2 <= q1;
					q3 <= q2;
				end
			end
			assign s2[g] = q2;
			assign s3[g] = q3;
		end
	endgenerate

	// One event per press; edges taken only after the second flop
	assign rise   = s2 & ~s3;
	assign mfi    = s2[`LRR_NUM_MFI-1:0];
	assign rev_p  = rise[`LRR_NUM_MFI];
	assign stop_p = rise[`LRR_NUM_MFI+1];
	assign run_p  = rise[`LRR_NUM_MFI+2];
	assign esc_p  = rise[`LRR_NUM_MFI+3];
	assign strap  = s2[`LRR_NUM_MFI+4];

	// Terminal functions by configured code
	assign fx     = fn_on(mfi, cfg.mfi_function, `LRR_FN_FX);
	assign rx     = fn_on(mfi, cfg.mfi_function, `LRR_FN_RX);
	assign permit = fn_on(mfi, cfg.mfi_function, `LRR_FN_RUN_PERMIT);
	assign jogf   = fn_on(mfi, cfg.mfi_function, `LRR_FN_JOG_FWD);
	assign jogr   = fn_on(mfi, cfg.mfi_function, `LRR_FN_JOG_REV);
	assign pre    = fn_on(mfi, cfg.mfi_function, `LRR_FN_PRE_EXCITE);

	// Source decode; unknown codes 6 and 7 act as digital sources
	assign src_term    = (cfg.cmd_source == `LRR_SRC_TWO_WIRE) |
	                     (cfg.cmd_source == `LRR_SRC_RUN_DIR);
	assign src_digital = ~src_term;
	assign keypad_ctl  = (mode == LRR_LOCAL) | (cfg.cmd_source == `LRR_SRC_KEYPAD);

	// Boot counter waits until the strap has crossed the synchroniser
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			boot_cnt <= 2'h0;
		end else if (boot_cnt != 2'h3) begin
			boot_cnt <= boot_cnt + 2'h1;
		end
	end
	assign boot_cap = (boot_cnt == `LRR_BOOT_SETTLE);
	assign boot_done = (boot_cnt > `LRR_BOOT_SETTLE);

	// Option edge detector for the local/remote setting
	assign en = (cfg.escape_key_function == `LRR_ESC_LOCREM);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en;
		end
	end

	// Mode transitions; settings are only read here, never written
	assign go_local  = ~boot_cap & ~(en & ~en_q) & en & esc_p & (mode == LRR_REMOTE);
	assign go_remote = ~boot_cap & ((en & ~en_q & (mode == LRR_LOCAL)) |
	                   (en & en_q & esc_p & (mode == LRR_LOCAL)));

	// Control mode register, remote after reset; boot loads local if the strap is set
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode <= LRR_REMOTE;
		end else if (boot_cap) begin
			mode <= strap ? LRR_LOCAL : LRR_REMOTE;
		end else if (en & ~en_q) begin
			mode <= LRR_REMOTE;
		end else if (go_local) begin
			mode <= LRR_LOCAL;
		end else if (go_remote) begin
			mode <= LRR_REMOTE;
		end
	end

	// Post-fault flag, caught once after reset release
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			post_fault <= 1'b0;
		end else if (boot_cap) begin
			post_fault <= strap;
		end
	end

	// Terminal arming: power-on run, or an off cycle first, a full one after a fault-reset return to remote
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			term_armed   <= 1'b0;
			need_all_off <= 1'b0;
		end else if (boot_cap) begin
			term_armed   <= cfg.run_on_powerup & src_term;
			need_all_off <= 1'b0;
		end else if (go_remote & post_fault) begin
			term_armed   <= 1'b0;
			need_all_off <= 1'b1;
		end else if (!term_armed && boot_done) begin // Held pins must not arm before boot
			// Off then on again: arming waits for the listed run inputs off, or for every input off after a fault-reset return
			if (need_all_off ? (mfi == '0) : ~(fx | rx | jogf | jogr | pre)) begin
				term_armed   <= 1'b1;
				need_all_off <= 1'b0;
			end
		end
	end

	// Power-up start pending until the first run begins or the mode changes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_start <= 1'b0;
		end else if (boot_cap) begin
			pwr_start <= cfg.run_on_powerup & src_term;
		end else if (drv.run | go_local | go_remote) begin
			pwr_start <= 1'b0;
		end
	end

	// Keypad and digital-source run state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			rev_q <= 1'b0;
		end else if (go_local) begin
			run_q <= 1'b0;
		end else if (go_remote) begin
			run_q <= 1'b0;
		end else if (keypad_ctl) begin
			if (stop_p) begin
				run_q <= 1'b0;
			end else if (rev_p & (cfg.dir_lock != `LRR_LOCK_NONE)) begin
				run_q <= 1'b0;
			end else if (run_p) begin
				run_q <= 1'b1;
			end else if (rev_p) begin
				rev_q <= ~rev_q;
			end
		end else if (rmt_cmd_valid) begin
			run_q <= rmt_run;
			rev_q <= rmt_rev;
		end
	end

	// Terminal command decode
	always_comb begin
		if (cfg.cmd_source == `LRR_SRC_TWO_WIRE) begin
			t_run = fx ^ rx;
			t_rev = rx & ~fx;
		end else begin
			t_run = fx;
			t_rev = rx;
		end
	end

	// Follow the terminals live in remote, so a switch keeps running
	assign want_run = (keypad_ctl | src_digital) ? run_q : (term_armed & t_run);
	assign want_rev = (keypad_ctl | src_digital) ? rev_q : t_rev;
	assign blocked  = ((cfg.dir_lock == `LRR_LOCK_FWD) & ~want_rev) |
	                  ((cfg.dir_lock == `LRR_LOCK_REV) & want_rev);
	assign next_run = want_run & ~blocked;

	// Registered decisions to the output stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			drv <= '0;
		end else begin
			drv.run         <= next_run;
			drv.reverse     <= want_rev;
			// Local jog needs the permit terminal
			drv.jog         <= (mode == LRR_LOCAL) ? (permit & (jogf | jogr)) :
			                   (src_term & term_armed & (jogf | jogr));
			drv.jog_reverse <= jogr & ~jogf;
			drv.pre_excite  <= (mode == LRR_REMOTE) & src_term & term_armed & pre;
			drv.speed_search <= next_run & ~drv.run & pwr_start &
			                    cfg.speed_search_options[`LRR_SS_PWRON_BIT];
			drv.accel_from_zero <= next_run & ~drv.run & ~(pwr_start &
			                    cfg.speed_search_options[`LRR_SS_PWRON_BIT]);
		end
	end

	// Lamp flashes in local mode, dark in remote
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flash_cnt  <= 32'h0000_0000;
			local_lamp <= 1'b0;
		end else if (mode == LRR_REMOTE) begin
			flash_cnt  <= 32'h0000_0000;
			local_lamp <= 1'b0;
		end else if (flash_cnt == 32'(FLASH_CYC - 1)) begin
			flash_cnt  <= 32'h0000_0000;
			local_lamp <= ~local_lamp;
		end else begin
			flash_cnt  <= flash_cnt + 32'h0000_0001;
			if (flash_cnt == 32'h0000_0000) begin
				local_lamp <= 1'b1;
			end
		end
	end

	assign local_mode = (mode == LRR_LOCAL);

	// Checks
	property p_esc_to_local;
		@(posedge core_clk) disable iff (!rst_n) go_local |=> (mode == LRR_LOCAL) ##1 local_lamp;
	endproperty
	a_esc_to_local: assert property (p_esc_to_local) else $error("no local entry");
	property p_esc_to_remote;
		@(posedge core_clk) disable iff (!rst_n) go_remote |=> ##1 !local_lamp;
	endproperty
	a_esc_to_remote: assert property (p_esc_to_remote) else $error("lamp on in remote");
	property p_opt_remote;
		@(posedge core_clk) disable iff (!rst_n) (en && !en_q && !boot_cap) |=> mode == LRR_REMOTE;
	endproperty
	a_opt_remote: assert property (p_opt_remote) else $error("option not remote");
	property p_local_stop;
		@(posedge core_clk) disable iff (!rst_n) go_local ##1 !run_p |=> !drv.run;
	endproperty
	a_local_stop: assert property (p_local_stop) else $error("ran after local");
	property p_jog_permit;
		@(posedge core_clk) disable iff (!rst_n) (mode == LRR_LOCAL && !permit) |=> !drv.jog;
	endproperty
	a_jog_permit: assert property (p_jog_permit) else $error("jog w/o permit");
	property p_no_pwr_run;
		@(posedge core_clk) disable iff (!rst_n)
			(boot_cap && !(cfg.run_on_powerup && src_term)) |=> !term_armed;
	endproperty
	a_no_pwr_run: assert property (p_no_pwr_run) else $error("armed at power-up");
	property p_lock;
		@(posedge core_clk) disable iff (!rst_n)
			drv.run |-> !($past(cfg.dir_lock) == `LRR_LOCK_REV && drv.reverse);
	endproperty
	a_lock: assert property (p_lock) else $error("locked direction ran");
	property p_two_wire_stop;
		@(posedge core_clk) disable iff (!rst_n)
			(!keypad_ctl && cfg.cmd_source == `LRR_SRC_TWO_WIRE && fx == rx) |=> !drv.run;
	endproperty
	a_two_wire_stop: assert property (p_two_wire_stop) else $error("two-wire not stop");
	c_toggle: cover property (@(posedge core_clk) disable iff (!rst_n) go_local ##[1:50] go_remote);
	c_pwr_run: cover property (@(posedge core_clk) disable iff (!rst_n) pwr_start ##1 drv.run);
	c_search: cover property (@(posedge core_clk) disable iff (!rst_n) drv.speed_search);
	c_term_rev: cover property (@(posedge core_clk) disable iff (!rst_n) drv.run && drv.reverse);
endmodule

/* testbench/lrr_keypad_term_model.sv */
// Purpose: Keypad keys and terminal pins that face the arbiter
// Assumes: Called at a clock edge plus 1 ns; returns at the same phase
// Notes:   keys[0] escape, [1] run, [2] stop, [3] reverse
`timescale 1ns/1ps
`include "lrr_defs.svh"
module lrr_keypad_term_model (
	input  wire logic                    core_clk,
	output logic [3:0]                   keys,
	output logic [`LRR_NUM_MFI-1:0]      terms
);
	// Pins start released so nothing is armed by accident
	initial begin
		keys  = 4'h0;
		terms = 7'h00;
	end

	// One press; long release so the sync stage sees one edge
	task automatic press(input int idx);
		keys[idx] = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 keys[idx] = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	// Terminal levels; the bench cycles them off and on to re-arm
	task automatic set_terms(input logic [`LRR_NUM_MFI-1:0] v);
		terms = v;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
endmodule

/* testbench/lrr_arbiter_tb_top.sv */
// Purpose: Self-checking bench of the local/remote run arbiter
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Lamp flash period shortened to 4 cycles
`timescale 1ns/1ps
`include "lrr_defs.svh"
module lrr_arbiter_tb_top;
	import lrr_pkg::*;
	typedef struct packed {
		logic [2:0] src;
		logic [1:0] lock;
		logic       fx;
		logic       rx;
		logic       run;
		logic       rev;
	} lrr_row_s;
	logic       core_clk;
	logic       rst_n;
	logic       strap;
	logic       rmt_valid;
	logic       rmt_run;
	logic       rmt_rev;
	lrr_cfg_s   cfg;
	lrr_drv_s   drv;
	logic       local_mode;
	logic       local_lamp;
	logic [3:0] keys;
	logic [6:0] terms;
	logic       seen_ss;
	logic       seen_acc;
	logic       lamp_hi;
	logic       lamp_lo;
	int         bad_count;
	int         n_compared;
	int         cyc;
	lrr_row_s   rows [10];

	lrr_keypad_term_model pm (.core_clk(core_clk), .keys(keys), .terms(terms));

	lrr_arbiter #(.FLASH_CYC(4)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .fault_reset_strap(strap),
		.key_esc(keys[0]), .key_run(keys[1]), .key_stop(keys[2]), .key_rev(keys[3]),
		.multifunction_inputs(terms), .rmt_cmd_valid(rmt_valid), .rmt_run(rmt_run),
		.rmt_rev(rmt_rev), .drv(drv), .local_mode(local_mode), .local_lamp(local_lamp)
	);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Catch start pulses, which last one cycle only
	always @(posedge core_clk) begin
		if (drv.speed_search === 1'b1) seen_ss = 1'b1;
		if (drv.accel_from_zero === 1'b1) seen_acc = 1'b1;
	end

	// Hang guard, well above the length of the whole sequence
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Two-cycle reset, then room for the boot settle
	task automatic do_reset();
		rst_n = 1'b0;
		cycles(2);
		rst_n = 1'b1;
		seen_ss = 1'b0;
		seen_acc = 1'b0;
		cycles(8);
	endtask

	task automatic remote_cmd(input logic run, input logic rev);
		rmt_valid = 1'b1;
		rmt_run = run;
		rmt_rev = rev;
		cycles(1);
		rmt_valid = 1'b0;
		cycles(4);
	endtask

	initial begin
		rows = '{'{3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0}, '{3'h1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0},
			'{3'h1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1}, '{3'h1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0},
			'{3'h2, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0}, '{3'h2, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1},
			'{3'h2, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0}, '{3'h1, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0},
			'{3'h1, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0}, '{3'h1, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0}};
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		cfg = '0;
		cfg.escape_key_function = `LRR_ESC_LOCREM;
		cfg.cmd_source = `LRR_SRC_TWO_WIRE;
		cfg.mfi_function[0] = `LRR_FN_FX;
		cfg.mfi_function[1] = `LRR_FN_RX;
		cfg.mfi_function[2] = `LRR_FN_RUN_PERMIT;
		cfg.mfi_function[3] = `LRR_FN_JOG_FWD;
		cfg.mfi_function[4] = `LRR_FN_JOG_REV;
		cfg.mfi_function[5] = `LRR_FN_PRE_EXCITE;
		cfg.mfi_function[6] = 6'h3f; // A function with no role here
		{strap, rmt_valid, rmt_run, rmt_rev, rst_n} = 5'h00;
		#1;
		// Forward and pre-excite held through power-up must not start the drive
		fork
			pm.set_terms(7'h21);
			do_reset();
		join
		check(local_mode, 1'b0);
		check(local_lamp, 1'b0);
		check(drv.run, 1'b0);
		check(drv.pre_excite, 1'b0);
		pm.set_terms(7'h00);
		pm.set_terms(7'h21);
		check(drv.run, 1'b1);
		check(drv.pre_excite, 1'b1);
		// Terminal decoding and direction lock table
		foreach (rows[i]) begin
			cfg.cmd_source = rows[i].src;
			cfg.dir_lock = rows[i].lock;
			pm.set_terms({5'h00, rows[i].rx, rows[i].fx});
			check(drv.run, rows[i].run);
			if (rows[i].run) check(drv.reverse, rows[i].rev);
		end
		// Remote to local stops; lamp flashes; keypad run works
		cfg.dir_lock = `LRR_LOCK_NONE;
		pm.press(0);
		check(local_mode, 1'b1);
		check(drv.run, 1'b0);
		{lamp_hi, lamp_lo} = 2'h0;
		for (int i = 0; i < 10; i++) begin
			if (local_lamp === 1'b1) lamp_hi = 1'b1;
			if (local_lamp === 1'b0) lamp_lo = 1'b1;
			cycles(1);
		end
		check(lamp_hi & lamp_lo, 1'b1);
		pm.set_terms(7'h08);
		check(drv.jog, 1'b0);
		pm.set_terms(7'h0c);
		check(drv.jog, 1'b1);
		check(drv.jog_reverse, 1'b0);
		pm.set_terms(7'h14);
		check(drv.jog, 1'b1);
		check(drv.jog_reverse, 1'b1);
		pm.set_terms(7'h02);
		pm.press(1);
		check(drv.run, 1'b1);
		check(drv.reverse, 1'b0);
		// Back to remote: terminals take over, reverse input alone runs reverse
		pm.press(0);
		check(local_mode, 1'b0);
		check(local_lamp, 1'b0);
		check(drv.run, 1'b1);
		check(drv.reverse, 1'b1);
		// Escape ignored unless option 2; re-selecting it forces remote
		pm.press(0);
		cfg.escape_key_function = 2'h1;
		pm.press(0);
		check(local_mode, 1'b1);
		cfg.escape_key_function = `LRR_ESC_LOCREM;
		cycles(6);
		check(local_mode, 1'b0);
		// Keypad source in remote: run and stop keys act
		cfg.cmd_source = `LRR_SRC_KEYPAD;
		pm.press(1);
		check(drv.run, 1'b1);
		pm.press(2);
		check(drv.run, 1'b0);
		// Digital source: command, then a mode round trip stops it
		cfg.cmd_source = `LRR_SRC_SERIAL;
		pm.set_terms(7'h00);
		remote_cmd(1'b1, 1'b0);
		check(drv.run, 1'b1);
		pm.press(0);
		pm.press(0);
		check(drv.run, 1'b0);
		remote_cmd(1'b1, 1'b0);
		check(drv.run, 1'b1);
		remote_cmd(1'b1, 1'b1);
		check(drv.reverse, 1'b1);
		remote_cmd(1'b0, 1'b0);
		check(drv.run, 1'b0);
		// Reverse key under a lock stops the drive
		pm.press(0);
		remote_cmd(1'b1, 1'b0);
		check(drv.run, 1'b0);
		cfg.dir_lock = `LRR_LOCK_REV;
		pm.press(1);
		check(drv.run, 1'b1);
		pm.press(3);
		check(drv.run, 1'b0);
		// Power-on run, with and without speed search
		cfg = '{default: '0, mfi_function: cfg.mfi_function, escape_key_function: 2'h2};
		cfg.cmd_source = `LRR_SRC_TWO_WIRE;
		cfg.run_on_powerup = 1'b1;
		cfg.speed_search_options = 8'hff;
		pm.set_terms(7'h01);
		do_reset();
		check(drv.run, 1'b1);
		check(seen_ss, 1'b1);
		cfg.speed_search_options = 8'hef;
		do_reset();
		check(seen_acc, 1'b1);
		check(seen_ss, 1'b0);
		cfg.cmd_source = `LRR_SRC_USER_SEQ;
		do_reset();
		check(drv.run, 1'b0);
		// After a fault reset: local at power-on, terminals need a full release
		cfg.cmd_source = `LRR_SRC_TWO_WIRE;
		cycles(3);
		check(drv.run, 1'b0);
		cfg.run_on_powerup = 1'b0;
		strap = 1'b1;
		do_reset();
		check(local_mode, 1'b1);
		pm.press(0);
		check(drv.run, 1'b0);
		pm.set_terms(7'h40);
		pm.set_terms(7'h41);
		check(drv.run, 1'b0);
		pm.set_terms(7'h00);
		pm.set_terms(7'h01);
		check(drv.run, 1'b1);
		summarize();
	end
endmodule
